// ==== hdl/adc_conversion_control_consts.svh ====
// Purpose: offsets, field positions, reset values and counts of the
//          converter control block
// Assumes: byte addresses on a 32-bit Avalon-MM slave port
// Notes:   included by the control design file and by the test bench
`ifndef ADC_CONVERSION_CONTROL_CONSTS_SVH
`define ADC_CONVERSION_CONTROL_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CONTROL 7'h00
`define OFS_RESULT 7'h04
`define OFS_IRQ_STATUS 7'h08
`define OFS_IRQ_MASK 7'h0c
`define OFS_CAL_BASE 7'h40

// ****************************************************************
// control field positions
// ****************************************************************
`define CTRL_GO_BIT 0
`define CTRL_REPEAT_BIT 1
`define CTRL_ENABLE_BIT 2
`define CTRL_SEL_LSB 4
`define CTRL_SEL_MSB 6

// ****************************************************************
// reset values
// ****************************************************************
`define CTRL_RESET 8'h00
`define MASK_RESET 1'b0
`define RESULT_RESET 11'h000

// ****************************************************************
// counts
// ****************************************************************
`define CONV_CYCLES 256
`define INPUT_COUNT 8
`define CAL_BYTES 9
`define RESULT_BITS 11

`endif

// ==== hdl/adc_conversion_control_pkg.sv ====
// Purpose: types shared by the converter control files
// Assumes: constants come from the consts header
// Notes:   fields are packed so they travel as one carrier
package adc_conversion_control_pkg;

  // ****************************************************************
  // control register layout
  // ****************************************************************
  typedef struct packed {
    logic [2:0] inputSel;
    logic enable;
    logic repeat_conversion_sel;
    logic conversion_go;
  } ctrl_t;

  // ****************************************************************
  // one finished conversion
  // ****************************************************************
  typedef struct packed {
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
  } result_t;

  // ****************************************************************
  // converter sequencing states
  // ****************************************************************
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONVERT
  } conv_state_t;

  // ****************************************************************
  // bus access phases
  // ****************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_FETCH,
    BUS_ANSWER
  } bus_phase_t;

endpackage

// ==== hdl/cal_byte_store.sv ====
// Purpose: small store for the calibration bytes
// Assumes: one write port, one read port, same clock
// Notes:   read data come out of a register one edge after the address
module cal_byte_store #(
  parameter int DEPTH = 9,
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic writeEn,
  input wire logic [ADDR_W-1:0] writeAddr,
  input wire logic [7:0] writeData,
  input wire logic [ADDR_W-1:0] readAddr,
  output logic [7:0] readData
);

  logic [7:0] mem [DEPTH];

  // ****************************************************************
  // storage
  // ****************************************************************
  // cleared at reset so an unprogrammed part reads zero, not unknown
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (writeEn && (int'(writeAddr) < DEPTH)) begin
      mem[writeAddr] <= writeData;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      readData <= 8'h00;
    end else if (int'(readAddr) < DEPTH) begin
      readData <= mem[readAddr];
    end else begin
      readData <= 8'h00;
    end
  end

endmodule // cal_byte_store

// ==== hdl/adc_conversion_control.sv ====
// Purpose: control logic of a sigma-delta converter behind an
//          Avalon-MM slave
// Assumes: modulator bit stream arrives asynchronously on a pin
// Notes:   every access answers on the third edge after it starts
`include "adc_conversion_control_consts.svh"

module adc_conversion_control
  import adc_conversion_control_pkg::*;
#(
  parameter int CONV_LEN = `CONV_CYCLES,
  parameter int ADDR_W = 7
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic modulatorBit,
  output logic [2:0] analogInSel,
  output logic converterOn,
  output logic irq
);

  localparam int CNT_W = $clog2(CONV_LEN);
  localparam int ONES_W = CNT_W + 1;
  localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(CONV_LEN - 1);
  // word index of the first calibration byte
  localparam logic [ADDR_W-3:0] CAL_WORD =
    (ADDR_W-2)'(`OFS_CAL_BASE >> 2);

  // ****************************************************************
  // declarations
  // ****************************************************************
  ctrl_t ctrl;
  result_t result;
  conv_state_t state;
  bus_phase_t busPhase;
  logic irqStatus;
  logic irqMask;
  logic modMeta;
  logic modSync;
  logic [CNT_W-1:0] convCount;
  logic [ONES_W-1:0] onesCount;
  logic [ONES_W-1:0] onesFinal;
  logic [`RESULT_BITS-1:0] signedResult;
  logic convDone;
  logic firstDone;
  logic request;
  logic commit;
  logic commitWrite;
  logic commitRead;
  logic lane0;
  logic hitControl;
  logic hitResult;
  logic hitStatus;
  logic hitMask;
  logic hitCal;
  logic [3:0] calIndex;
  logic [7:0] calReadData;
  logic [31:0] next_readdata;
  logic goWrite;
  logic [7:0] highPart;
  logic [7:0] lowPart;

  // ****************************************************************
  // address decode
  // ****************************************************************
  assign request = avs_read || avs_write;
  // the access takes effect only at the edge that sees waitrequest low
  assign commit = request && (busPhase == BUS_ANSWER);
  assign commitWrite = commit && avs_write;
  assign commitRead = commit && avs_read;
  assign lane0 = avs_byteenable[0];
  assign hitControl = (avs_address == `OFS_CONTROL);
  assign hitResult = (avs_address == `OFS_RESULT);
  assign hitStatus = (avs_address == `OFS_IRQ_STATUS);
  assign hitMask = (avs_address == `OFS_IRQ_MASK);
  assign calIndex = 4'(avs_address[ADDR_W-1:2] - CAL_WORD);
  assign hitCal = (avs_address >= `OFS_CAL_BASE) &&
                  (avs_address[1:0] == 2'h0) &&
                  (int'(avs_address - `OFS_CAL_BASE) < 4 * `CAL_BYTES);
  assign goWrite = commitWrite && hitControl && lane0;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // two wait cycles for every access so the calibration store's
  // registered read has time to settle before readdata is loaded
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busPhase <= BUS_IDLE;
    end else begin
      case (busPhase)
        BUS_IDLE: begin
          if (request) begin
            busPhase <= BUS_FETCH;
          end
        end
        BUS_FETCH: begin
          busPhase <= BUS_ANSWER;
        end
        BUS_ANSWER: begin
          busPhase <= BUS_IDLE;
        end
        default: begin
          busPhase <= BUS_IDLE;
        end
      endcase
    end
  end

  // a register of its own, low for exactly the answer cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= (busPhase != BUS_FETCH);
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hitControl) begin
      next_readdata[`CTRL_GO_BIT] = ctrl.conversion_go;
      next_readdata[`CTRL_REPEAT_BIT] = ctrl.repeat_conversion_sel;
      next_readdata[`CTRL_ENABLE_BIT] = ctrl.enable;
      next_readdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = ctrl.inputSel;
    end else if (hitResult) begin
      next_readdata[15:0] = result;
    end else if (hitStatus) begin
      next_readdata[0] = irqStatus;
    end else if (hitMask) begin
      next_readdata[0] = irqMask;
    end else if (hitCal) begin
      next_readdata[7:0] = calReadData;
    end
  end

  // loaded one edge early so it already stands when waitrequest drops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (busPhase == BUS_FETCH) begin
      avs_readdata <= next_readdata;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= ctrl_t'(6'(`CTRL_RESET));
    end else begin
      if (goWrite) begin
        ctrl.repeat_conversion_sel <=
          avs_writedata[`CTRL_REPEAT_BIT];
        ctrl.enable <= avs_writedata[`CTRL_ENABLE_BIT];
        ctrl.inputSel <= avs_writedata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
      end
      if (firstDone || (state == ST_CONVERT && !ctrl.enable)) begin
        // hardware clear wins; a go written while idle and enabled starts a new window
        ctrl.conversion_go <= 1'b0;
      end else if (goWrite) begin
        // go only takes while the converter is (being) enabled
        ctrl.conversion_go <= avs_writedata[`CTRL_GO_BIT] &&
                              avs_writedata[`CTRL_ENABLE_BIT];
      end
    end
  end

  // ****************************************************************
  // modulator input and pin outputs
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      modMeta <= 1'b0;
      modSync <= 1'b0;
    end else begin
      modMeta <= modulatorBit;
      modSync <= modMeta;
    end
  end

  // a single 3-bit select means exactly one input is ever routed
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      analogInSel <= 3'h0;
    end else begin
      analogInSel <= ctrl.inputSel;
    end
  end

  // registered so the analog side never sees a decode glitch
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      converterOn <= 1'b0;
    end else begin
      converterOn <= ctrl.enable;
    end
  end

  // ****************************************************************
  // conversion sequencing
  // ****************************************************************
  // enable in the term makes a disable abort the window at once
  assign convDone = (state == ST_CONVERT) && ctrl.enable &&
                    (convCount == LAST_COUNT);
  assign firstDone = convDone && ctrl.conversion_go;
  assign onesFinal = onesCount + ONES_W'(modSync);
  // twice the ones count less the window length gives a signed value
  assign signedResult = `RESULT_BITS'({onesFinal, 1'b0}) -
                        `RESULT_BITS'(CONV_LEN);
  // low byte keeps its spare bits zero so it reads as a left-aligned
  // fraction; software can join both bytes without masking
  assign highPart = signedResult[10:3];
  assign lowPart = {signedResult[2:0], 5'h00};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ctrl.conversion_go && ctrl.enable) begin
            state <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (!ctrl.enable) begin
            state <= ST_IDLE;
          end else if (convDone && !ctrl.repeat_conversion_sel) begin
            // clearing repeat lets the running window finish
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      convCount <= '0;
    end else if (state != ST_CONVERT || convDone) begin
      // counter wraps so repeated windows sit back to back
      convCount <= '0;
    end else begin
      convCount <= convCount + CNT_W'(1);
    end
  end

  // the ones tally spans exactly the window that convCount measures
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      onesCount <= '0;
    end else if (state != ST_CONVERT || convDone) begin
      onesCount <= '0;
    end else begin
      onesCount <= onesFinal;
    end
  end

  // ****************************************************************
  // result register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      result <= '0;
    end else if (convDone) begin
      result.result_high_byte <= highPart;
      result.result_low_byte <= lowPart;
    end
  end

  // ****************************************************************
  // interrupt
  // ****************************************************************
  // convDone already requires enable, so a disabled converter cannot
  // post; disabling never touches a pending bit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus <= 1'b0;
    end else if (convDone) begin
      irqStatus <= 1'b1;
    end else if (commitRead && hitStatus) begin
      irqStatus <= 1'b0;
    end
  end

  // the mask gates only the pin; status keeps recording events
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqMask <= `MASK_RESET;
    end else if (commitWrite && hitMask && lane0) begin
      irqMask <= avs_writedata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irqStatus && irqMask;
    end
  end

  // ****************************************************************
  // calibration bytes
  // ****************************************************************
  // three reference types, each offset then gain high then gain low
  cal_byte_store #(
    .DEPTH(`CAL_BYTES),
    .ADDR_W(4)
  ) u_cal (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .writeEn(commitWrite && hitCal && lane0),
    .writeAddr(calIndex),
    .writeData(avs_writedata[7:0]),
    .readAddr(calIndex),
    .readData(calReadData)
  );

endmodule // adc_conversion_control

// ==== testbench/adc_conversion_control_properties.sv ====
// Purpose: port-level properties of the converter control block
// Assumes: every access answers on its third edge, irq lags by one
// Notes:   bound to the design from the test top file
module adc_conversion_control_properties #(
  parameter int ADDR_W = 7
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic modulatorBit,
  input wire logic [2:0] analogInSel,
  input wire logic converterOn,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic req;
  logic done;
  assign req = avs_read || avs_write;
  assign done = !avs_waitrequest && avs_byteenable[0];
  // ****************************************************************
  // bus and control properties
  // ****************************************************************
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_answer_third: assert property (req && !$past(req) |->
    avs_waitrequest [*2] ##1 !avs_waitrequest)
    else $error("access not answered on third edge");
  a_idle_wait: assert property (!req && !$past(req) |-> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address == ADDR_W'(124) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_sel_follows: assert property (
    avs_write && done && avs_address == '0 |->
    ##2 analogInSel == $past(avs_writedata[6:4], 2))
    else $error("input select does not follow control");
  a_enable_mirror: assert property (
    avs_write && done && avs_address == '0 |->
    ##2 converterOn == $past(avs_writedata[2], 2))
    else $error("converter enable does not follow control");
  // ****************************************************************
  // interrupt properties
  // ****************************************************************
  a_mask_silences: assert property (avs_write && done &&
    avs_address == ADDR_W'(12) && !avs_writedata[0] |-> ##2 !irq)
    else $error("masked irq still high");
  a_read_clears: assert property (avs_read && !avs_waitrequest &&
    avs_address == ADDR_W'(8) |-> ##2 !irq)
    else $error("status read did not drop irq");
  a_pending_kept: assert property ($fell(converterOn) && irq |=> irq)
    else $error("pending irq lost on disable");
  a_off_quiet: assert property (
    !converterOn && !$past(converterOn) && !irq |=> !irq)
    else $error("irq raised while disabled");
endmodule // adc_conversion_control_properties

// ==== testbench/analog_source_model.sv ====
// Purpose: stand-in for the analog inputs and the modulator
// Assumes: odd inputs sit at full scale, even inputs at zero scale
// Notes:   a selection of the wrong parity flips the sign of the result
module analog_source_model (
  input wire logic clk_sys,
  input wire logic [2:0] analogInSel,
  input wire logic converterOn,
  output logic modulatorBit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idleToggle = 1'b0;
  initial modulatorBit = 1'b0;
  // a stopped modulator toggles so no stale level is mistaken for data
  always @(posedge clk_sys) begin
    idleToggle <= !idleToggle;
    modulatorBit <= converterOn ? analogInSel[0] : idleToggle;
  end
endmodule // analog_source_model

// ==== testbench/adc_conversion_control_test.sv ====
// Purpose: self-checking bench of the converter control block
// Assumes: default conversion length, fixed three-edge bus answer
// Notes:   results are full or zero scale, so only sign bits vary
`include "adc_conversion_control_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  n_fail++; $display("CHECK FAILED at %0t: got %h expected %h", \
  $time, (a), (b)); end end
module adc_conversion_control_test
  import adc_conversion_control_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV_LEN = `CONV_CYCLES;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] avsAddress = 7'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0] avsByteenable = 4'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic modulatorBit;
  logic [2:0] analogInSel;
  logic converterOn;
  logic irq;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  adc_conversion_control dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .modulatorBit(modulatorBit), .analogInSel(analogInSel),
    .converterOn(converterOn), .irq(irq));
  analog_source_model src (.clk_sys(clk_sys), .analogInSel(analogInSel),
    .converterOn(converterOn), .modulatorBit(modulatorBit));
  // ****************************************************************
  // bus and wait helpers
  // ****************************************************************
  task automatic bus(input logic wr, input logic [6:0] a,
    input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= wd;
    avsByteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    `CHK(n < 20, 1'b1)
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'h1, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, 4'hf, d);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic wait_irq(input logic lvl, output int at);
    int n;
    n = 0;
    while (irq !== lvl && n < 3 * CONV_LEN) begin
      @(negedge clk_sys);
      n++;
    end
    at = cyc;
    `CHK(irq, lvl)
  endtask
  task automatic quiet(input int n);
    logic saw;
    saw = 1'b0;
    repeat (n) begin
      @(negedge clk_sys);
      saw = saw | (irq !== 1'b0);
    end
    `CHK(saw, 1'b0)
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    rdchk(`OFS_CONTROL, 32'h0);
    rdchk(`OFS_IRQ_MASK, 32'h0);
    rdchk(`OFS_RESULT, 32'h0);
    wr(7'h7c, 32'h77);
    rdchk(7'h7c, 32'h0);
    rdchk(`OFS_CONTROL, 32'h0);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_cal;
    logic [31:0] junk;
    for (int i = 0; i < `CAL_BYTES; i++) wr(`OFS_CAL_BASE + 7'(4 * i),
      32'ha0 + i);
    bus(1'b1, `OFS_CAL_BASE, 32'hff, 4'h0, junk);
    for (int i = 0; i < `CAL_BYTES; i++) rdchk(`OFS_CAL_BASE + 7'(4 * i),
      32'ha0 + i);
  endtask
  task automatic t_single;
    int t0;
    int t;
    logic [31:0] d;
    result_t r;
    wr(`OFS_IRQ_MASK, 32'h1);
    // enable and select first so the modulator settles on the input
    wr(`OFS_CONTROL, 32'h34);
    t0 = cyc;
    wr(`OFS_CONTROL, 32'h35);
    wait_irq(1'b1, t);
    `CHK(analogInSel, 3'h3)
    `CHK(t - t0 >= CONV_LEN && t - t0 <= CONV_LEN + 12, 1'b1)
    rdchk(`OFS_CONTROL, 32'h34);
    rd(`OFS_RESULT, d);
    r = d[15:0];
    `CHK(r, 16'h2000)
    wr(`OFS_IRQ_MASK, 32'h0);
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'b0)
    wr(`OFS_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'b1)
    rdchk(`OFS_IRQ_STATUS, 32'h1);
    wait_irq(1'b0, t);
    rdchk(`OFS_IRQ_STATUS, 32'h0);
    quiet(2 * CONV_LEN);
  endtask
  task automatic t_nogo;
    wr(`OFS_CONTROL, 32'h01);
    rdchk(`OFS_CONTROL, 32'h0);
    quiet(CONV_LEN + 16);
  endtask
  task automatic t_repeat_conversion_sel;
    int t1;
    int t2;
    logic [31:0] d;
    result_t r;
    wr(`OFS_CONTROL, 32'h27);
    wait_irq(1'b1, t1);
    rdchk(`OFS_IRQ_STATUS, 32'h1);
    wait_irq(1'b0, t2);
    wait_irq(1'b1, t2);
    `CHK(t2 - t1, CONV_LEN)
    rdchk(`OFS_CONTROL, 32'h26);
    rd(`OFS_RESULT, d);
    r = d[15:0];
    `CHK(r.result_high_byte, 8'he0)
    `CHK(r.result_low_byte, 8'h00)
    wr(`OFS_CONTROL, 32'h24);
    rdchk(`OFS_IRQ_STATUS, 32'h1);
    wait_irq(1'b0, t1);
    wait_irq(1'b1, t1);
    rdchk(`OFS_IRQ_STATUS, 32'h1);
    wait_irq(1'b0, t1);
    quiet(2 * CONV_LEN);
    wr(`OFS_CONTROL, 32'h27);
    wait_irq(1'b1, t1);
    wr(`OFS_CONTROL, 32'h00);
    repeat (3) @(negedge clk_sys);
    `CHK(converterOn, 1'b0)
    `CHK(irq, 1'b1)
    rdchk(`OFS_IRQ_STATUS, 32'h1);
    wait_irq(1'b0, t1);
    quiet(2 * CONV_LEN);
  endtask
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_cal();
    t_single();
    t_nogo();
    t_repeat_conversion_sel();
    stop_test();
  end
  // the tests need about 3300 cycles, so this only fires on a hang
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
endmodule // adc_conversion_control_test

bind adc_conversion_control adc_conversion_control_properties #(
  .ADDR_W(ADDR_W)) props (.clk_sys(clk_sys), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .modulatorBit(modulatorBit), .analogInSel(analogInSel),
  .converterOn(converterOn), .irq(irq));
